// *** hw/trim_cfg.svh ***
// Offsets, field positions, reset values for the trim register bank
`ifndef TRIM_CFG_SVH
`define TRIM_CFG_SVH
`define TRIM_IDX_CH15_EVEN 8'h36
`define TRIM_IDX_CH16_ODD  8'h37
`define TRIM_IDX_CH16_EVEN 8'h38
`define TRIM_IDX_CFG3      8'h03
`define TRIM_GAIN_MSB      15
`define TRIM_GAIN_LSB      11
`define TRIM_RSVD_BIT      10
`define TRIM_OFFS_MSB      9
`define TRIM_OFFS_LSB      0
`define TRIM_CFG3_GAIN_BIT 12
`define TRIM_CFG3_OFFS_BIT 8
`define TRIM_RESET_VALUE   16'h0000
`define TRIM_GAIN_CDB      5'h02
`endif

// *** hw/trim_pkg.sv ***
// Types shared by the trim register bank
package trim_pkg;
    typedef logic [4:0]  gain_t;
    typedef logic [9:0]  offs_t;
    typedef logic [13:0] sample_t;
    typedef enum logic [1:0]
    {
        SEL_CH15_EVEN = 2'h0,
        SEL_CH16_ODD  = 2'h1,
        SEL_CH16_EVEN = 2'h3
    } trim_sel_e;
endpackage

// *** hw/channel_gain_offset_trim_regs.sv ***
// Per-sample gain and offset trim registers with Wishbone slave
// Behaviour
// R01: Gain applies only while cfg3 bit 12 set
// R02: Gain step is field value times 0.2 dB
// R03: Offset applies only while cfg3 bit 8 set
// R04: Offset is subtracted from the sample
// R05: Offset is bits 9..0, signed two's complement
// R06: Offset unit is one 14-bit LSB
// R07: Trim_ch15_even holds channel 15 even trim
// R08: Trim_ch16_odd holds channel 16 odd trim
// R09: Trim_ch16_even holds channel 16 even trim
// R10: Host writes bit 10 zero; all reset zero
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "trim_cfg.svh"
module channel_gain_offset_trim_regs
    import trim_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [9:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        smp_valid_i,
    input  wire logic [1:0]  smp_sel_i,
    input  wire logic [13:0] smp_i,
    output logic             smp_valid_o,
    output logic      [13:0] smp_o,
    output logic      [6:0]  gain_cdb_o,
    output logic             gain_active_o
);
    logic [15:0] trim_ch15_even;
    logic [15:0] trim_ch16_odd;
    logic [15:0] trim_ch16_even;
    logic [15:0] cfg3;
    logic        req;
    logic [7:0]  idx;
    logic        global_gain_apply;
    logic        global_offs_apply;
    logic [15:0] cur;
    logic [15:0] rd_word;

    // Register offsets are word indexes; byte address is four times
    assign idx = adr_i[9:2];
    assign req = cyc_i && stb_i && !ack_o;

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [15:0] r;
        r = old;
        if (s[0])
            r[7:0] = d[7:0];
        if (s[1])
            r[15:8] = d[15:8];
        return r;
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= req;
    end

    // R10 all fields reset zero
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            trim_ch15_even <= `TRIM_RESET_VALUE;
            trim_ch16_odd  <= `TRIM_RESET_VALUE;
            trim_ch16_even <= `TRIM_RESET_VALUE;
            cfg3           <= `TRIM_RESET_VALUE;
        end
        else if (req && we_i)
        begin
            case (idx)
                // R07 channel 15 even
                `TRIM_IDX_CH15_EVEN:
                    trim_ch15_even <= merge(trim_ch15_even, dat_i, sel_i);
                // R08 channel 16 odd
                `TRIM_IDX_CH16_ODD:
                    trim_ch16_odd <= merge(trim_ch16_odd, dat_i, sel_i);
                // R09 channel 16 even
                `TRIM_IDX_CH16_EVEN:
                    trim_ch16_even <= merge(trim_ch16_even, dat_i, sel_i);
                `TRIM_IDX_CFG3:
                    cfg3 <= merge(cfg3, dat_i, sel_i);
                default:
                    ;
            endcase
        end
    end

    always_comb
    begin
        case (idx)
            `TRIM_IDX_CH15_EVEN: rd_word = trim_ch15_even;
            `TRIM_IDX_CH16_ODD:  rd_word = trim_ch16_odd;
            `TRIM_IDX_CH16_EVEN: rd_word = trim_ch16_even;
            `TRIM_IDX_CFG3:      rd_word = cfg3;
            default:             rd_word = 16'h0000;
        endcase
    end

    // Unmapped reads ack with zero, never stall the bus
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            dat_o <= 32'h0000_0000;
        else if (req && !we_i)
            dat_o <= {16'h0000, rd_word};
    end

    assign global_gain_apply = cfg3[`TRIM_CFG3_GAIN_BIT];
    assign global_offs_apply = cfg3[`TRIM_CFG3_OFFS_BIT];

    always_comb
    begin
        case (smp_sel_i)
            SEL_CH15_EVEN: cur = trim_ch15_even;
            SEL_CH16_ODD:  cur = trim_ch16_odd;
            SEL_CH16_EVEN: cur = trim_ch16_even;
            default:       cur = 16'h0000;
        endcase
    end

    function automatic logic [13:0] sat14(input logic signed [15:0] v);
        if (v < 16'sd0)
            return 14'h0000;
        if (v > 16'sh3FFF)
            return 14'h3FFF;
        return v[13:0];
    endfunction

    logic signed [15:0] offs_ext;
    logic signed [15:0] diff;
    // R05 sign-extended offset
    assign offs_ext = {{6{cur[`TRIM_OFFS_MSB]}},
                       cur[`TRIM_OFFS_MSB:`TRIM_OFFS_LSB]};
    // R03 R04 R06 subtract in 14-bit LSB units when enabled
    assign diff = $signed({2'b00, smp_i})
                  - (global_offs_apply ? offs_ext : 16'sh0000);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            smp_valid_o   <= 1'b0;
            smp_o         <= 14'h0000;
            gain_cdb_o    <= 7'h00;
            gain_active_o <= 1'b0;
        end
        else
        begin
            smp_valid_o <= smp_valid_i;
            if (smp_valid_i)
            begin
                smp_o <= sat14(diff);
                // R01 R02 gain in 0.1 dB steps: N times 0.2 dB
                // Widen before the product: 31 steps need 6 bits
                gain_cdb_o <= global_gain_apply
                    ? 7'(cur[`TRIM_GAIN_MSB:`TRIM_GAIN_LSB])
                      * 7'(`TRIM_GAIN_CDB) : 7'h00;
                gain_active_o <= global_gain_apply;
            end
        end
    end

    property p_ack_one;
        @(posedge clk_i) disable iff (sys_rst_i)
        ack_o |=> !ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held");

    property p_ack_req;
        @(posedge clk_i) disable iff (sys_rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("no ack");

    property p_gain_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        (smp_valid_i && !global_gain_apply) |=> gain_cdb_o == 7'h00;
    endproperty
    a_gain_off: assert property (p_gain_off) else $error("gain leak"); // R01

    property p_gain_val;
        @(posedge clk_i) disable iff (sys_rst_i)
        (smp_valid_i && global_gain_apply) |=>
            gain_cdb_o == 7'($past(cur[15:11]) * 2);
    endproperty
    a_gain_val: assert property (p_gain_val) else $error("gain step"); // R02

    property p_offs_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        (smp_valid_i && !global_offs_apply) |=> smp_o == $past(smp_i);
    endproperty
    a_offs_off: assert property (p_offs_off) else $error("offs leak"); // R03

    property p_offs_sub;
        @(posedge clk_i) disable iff (sys_rst_i)
        (smp_valid_i && global_offs_apply && !cur[`TRIM_OFFS_MSB]
         && smp_i >= 14'(cur[8:0])) |=>
            smp_o == $past(smp_i) - 14'($past(cur[8:0]));
    endproperty
    a_offs_sub: assert property (p_offs_sub) else $error("offs sign"); // R04

    property p_offs_neg;
        @(posedge clk_i) disable iff (sys_rst_i)
        (smp_valid_i && global_offs_apply && cur[`TRIM_OFFS_MSB]
         && smp_i <= 14'h3000) |=>
            smp_o == $past(smp_i) + (14'h0400 - 14'($past(cur[9:0])));
    endproperty
    a_offs_neg: assert property (p_offs_neg) else $error("offs twos"); // R05

    property p_wr36;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req && we_i && idx == 8'h36 && sel_i[1:0] == 2'b11) |=>
            trim_ch15_even == $past(dat_i[15:0]);
    endproperty
    a_wr36: assert property (p_wr36) else $error("36 write"); // R07

    property p_wr37;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req && we_i && idx == 8'h37 && sel_i[1:0] == 2'b11) |=>
            trim_ch16_odd == $past(dat_i[15:0])
            && $stable(trim_ch16_even) && $stable(trim_ch15_even);
    endproperty
    a_wr37: assert property (p_wr37) else $error("37 alias"); // R08

    property p_wr38;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req && we_i && idx == 8'h38 && sel_i[1:0] == 2'b11) |=>
            trim_ch16_even == $past(dat_i[15:0]);
    endproperty
    a_wr38: assert property (p_wr38) else $error("38 write"); // R09

    property p_valid_pipe;
        @(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |=> smp_valid_o == $past(smp_valid_i);
    endproperty
    a_valid_pipe: assert property (p_valid_pipe) else $error("valid lag");

    property p_gain_act;
        @(posedge clk_i) disable iff (sys_rst_i)
        smp_valid_i |=> gain_active_o == $past(global_gain_apply);
    endproperty
    a_gain_act: assert property (p_gain_act) else $error("gain flag"); // R01

    property p_smp_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        !smp_valid_i |=>
            $stable(smp_o) && $stable(gain_cdb_o) && $stable(gain_active_o);
    endproperty
    a_smp_hold: assert property (p_smp_hold) else $error("smp moved");

    property p_clamp_hi;
        @(posedge clk_i) disable iff (sys_rst_i)
        (smp_valid_i && global_offs_apply && cur[`TRIM_OFFS_MSB]
         && smp_i == 14'h3FFF) |=> smp_o == 14'h3FFF;
    endproperty
    a_clamp_hi: assert property (p_clamp_hi) else $error("clamp high"); // R04

    property p_clamp_lo;
        @(posedge clk_i) disable iff (sys_rst_i)
        (smp_valid_i && global_offs_apply && !cur[`TRIM_OFFS_MSB]
         && smp_i < 14'(cur[8:0])) |=> smp_o == 14'h0000;
    endproperty
    a_clamp_lo: assert property (p_clamp_lo) else $error("clamp low"); // R04

    property p_lane_hi;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req && we_i && idx == 8'h36 && sel_i[1:0] == 2'b10) |=>
            trim_ch15_even[15:8] == $past(dat_i[15:8])
            && $stable(trim_ch15_even[7:0]);
    endproperty
    a_lane_hi: assert property (p_lane_hi) else $error("lane merge"); // R07

    property p_rd_odd;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req && !we_i && idx == 8'h37) |=>
            dat_o == {16'h0000, $past(trim_ch16_odd)};
    endproperty
    a_rd_odd: assert property (p_rd_odd) else $error("37 read"); // R08

    property p_rd_none;
        @(posedge clk_i) disable iff (sys_rst_i)
        (req && !we_i && idx > 8'h38) |=> dat_o == 32'h0000_0000;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("unmapped read");

    property p_dat_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        !(req && !we_i) |=> $stable(dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("dat moved");

    // No disable here: the reset itself is the antecedent
    property p_rst_zero;
        @(posedge clk_i)
        sys_rst_i |=> !ack_o && !smp_valid_o && cfg3 == 16'h0000
            && trim_ch15_even == 16'h0000 && trim_ch16_odd == 16'h0000
            && trim_ch16_even == 16'h0000 && dat_o == 32'h0000_0000;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("reset left"); // R10

    c_write: cover property (@(posedge clk_i) req && we_i);
    c_read: cover property (@(posedge clk_i) req && !we_i);
    c_both: cover property (@(posedge clk_i)
        smp_valid_i && global_gain_apply && global_offs_apply);
    c_clamp: cover property (@(posedge clk_i)
        smp_valid_i && global_offs_apply && diff < 16'sh0000);
    c_unmapped: cover property (@(posedge clk_i) req && idx > 8'h38);
endmodule

// *** test/tb.sv ***
// Self-checking bench for the trim register bank
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb;
    import trim_pkg::*;
    typedef struct { logic [9:0] a; logic [15:0] d; logic [3:0] s;
                     logic [15:0] e; } reg_row_s;
    typedef struct { logic [15:0] c; logic [1:0] s; logic [13:0] v; } smp_row_s;
    logic        clk_i, sys_rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [9:0]  adr_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic        smp_valid_i, smp_valid_o, gain_active_o;
    logic [1:0]  smp_sel_i;
    logic [13:0] smp_i, smp_o;
    logic [6:0]  gain_cdb_o;
    int          fails, num_checks;
    // Selector 2 carries no trim, so its slot stays zero
    logic [15:0] trim_val [4] = '{16'h1805, 16'hFBFF, 16'h0000, 16'h0A00};
    // trim writes keep bit 10 clear
    reg_row_s rr [6] = '{
        '{10'h0D8, 16'h1805, 4'h3, 16'h1805}, '{10'h0D8, 16'hFBFF, 4'h2, 16'hFB05},
        '{10'h0D8, 16'h1805, 4'h3, 16'h1805}, '{10'h0DC, 16'hFBFF, 4'h3, 16'hFBFF},
        '{10'h0E0, 16'h0A00, 4'h3, 16'h0A00}, '{10'h3FC, 16'hFFFF, 4'h3, 16'h0000}};
    smp_row_s sr [8] = '{
        '{16'h0000, 2'h0, 14'h0064}, '{16'h1100, 2'h0, 14'h0064},
        '{16'h1100, 2'h1, 14'h0064}, '{16'h1100, 2'h3, 14'h3FFF},
        '{16'h1100, 2'h0, 14'h0002}, '{16'h1100, 2'h2, 14'h004D},
        '{16'h1000, 2'h0, 14'h0064}, '{16'h0100, 2'h3, 14'h0010}};
    channel_gain_offset_trim_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .smp_valid_i(smp_valid_i), .smp_sel_i(smp_sel_i), .smp_i(smp_i),
        .smp_valid_o(smp_valid_o), .smp_o(smp_o), .gain_cdb_o(gain_cdb_o),
        .gain_active_o(gain_active_o));
    function automatic logic [13:0] exp_smp(input logic [1:0] s,
        input logic [13:0] v, input logic [15:0] c);
        int o;
        o = v;
        if (c[8])
            o = o - {{22{trim_val[s][9]}}, trim_val[s][9:0]};
        if (o < 0)
            o = 0;
        if (o > 16383)
            o = 16383;
        return o[13:0];
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wb(input logic [9:0] a, input logic w, input logic [15:0] d,
        input logic [3:0] s, output logic [31:0] r);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
        dat_i <= {16'h0000, d}; sel_i <= s;
        // Only ack_o or the watchdog may end this wait
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
    endtask
    task automatic smp(input logic [1:0] s, input logic [13:0] v,
        input logic [15:0] c);
        @(posedge clk_i);
        smp_valid_i <= 1'b1; smp_sel_i <= s; smp_i <= v;
        @(posedge clk_i);
        smp_valid_i <= 1'b0;
        #1;
        `CHK(smp_valid_o, 1'b1)
        `CHK(smp_o, exp_smp(s, v, c))
        `CHK(gain_cdb_o, c[12] ? {1'b0, trim_val[s][15:11], 1'b0} : 7'h00)
        `CHK(gain_active_o, c[12])
    endtask
    initial
    begin
        clk_i = 0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        stop_test();
    end
    initial
    begin
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
        {smp_valid_i, smp_sel_i, smp_i} = '0;
        fails = 0; num_checks = 0;
        sys_rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK({ack_o, smp_valid_o, gain_active_o}, 3'b000)
        for (int i = 0; i < 3; i++)
        begin
            wb(10'h0D8 + 10'(i * 4), 1'b0, 16'h0000, 4'h3, q);
            `CHK(q, 32'h0000_0000)
        end
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            wb(rr[i].a, 1'b1, rr[i].d, rr[i].s, q);
            wb(rr[i].a, 1'b0, 16'h0000, 4'h3, q);
            `CHK(q, {16'h0000, rr[i].e})
        end
        $display("test registers done");
        for (int i = 0; i < 8; i++)
        begin
            wb(10'h00C, 1'b1, sr[i].c, 4'h3, q);
            smp(sr[i].s, sr[i].v, sr[i].c);
        end
        $display("test samples done");
        // Mid-run reset must clear trims and the apply bits
        @(posedge clk_i);
        sys_rst_i <= 1'b1;
        @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        `CHK({smp_o, gain_active_o}, 15'h0000)
        for (int i = 0; i < 3; i++)
        begin
            wb(10'h0D8 + 10'(i * 4), 1'b0, 16'h0000, 4'h3, q);
            `CHK(q, 32'h0000_0000)
        end
        wb(10'h00C, 1'b0, 16'h0000, 4'h3, q);
        `CHK(q, 32'h0000_0000)
        $display("test second reset done");
        stop_test();
    end
endmodule
